// ---- pkg/fao_cfg.svh ----
// constants for the flash converter output port
`ifndef FAO_CFG_SVH
`define FAO_CFG_SVH

// ------------------------------------------------------------
// widths and depths
// ------------------------------------------------------------
`define FAO_DATA_W 8
`define FAO_FIFO_DEPTH 32
`define FAO_SYNC_STAGES 3

// ------------------------------------------------------------
// codes and reset values
// ------------------------------------------------------------
`define FAO_CODE_ALL_ONES 8'h00ff
`define FAO_CODE_RESET 8'h0000
`define FAO_OVF_RESET 1'h0
`define FAO_EN_N_IDX 0
`define FAO_EN_HI_IDX 1

// ------------------------------------------------------------
// timing: clock and sample rate limits, in kHz / ksps
// ------------------------------------------------------------
`define FAO_CLK_KHZ 25000
`define FAO_MAX_RATE_KSPS 20000
`define FAO_MIN_RATE_KSPS 125

`endif

// ---- pkg/fao_pkg.sv ----
// types shared by the flash converter output port
`default_nettype none
package fao_pkg;

    // ------------------------------------------------------------
    // drive modes of the three-state output stage
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FAO_DRIVE_ALL,
        FAO_DRIVE_OVF,
        FAO_DRIVE_NONE
    } fao_drive_t;

endpackage
`default_nettype wire

// ---- src/fao_fifo.sv ----
// result fifo with registered read data and registered flags
`timescale 1ns/1ps
`default_nettype none

module fao_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    // pointers wrap naturally, so depth must be a power of two
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    logic [AW:0] count_d;
    logic room_q;
    logic outValid_q;
    logic [WIDTH-1:0] outData_q;

    // ------------------------------------------------------------
    // push / pop decode
    // ------------------------------------------------------------
    // pop refills the output register whenever it is free or drained
    wire push = inValid && room_q;
    wire pop = (count_q != '0) && (!outValid_q || outReady);
    wire drain = outValid_q && outReady;
    assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);

    // storage array, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // pointers, level and registered flags
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            room_q <= 1'b1;
            outValid_q <= 1'b0;
            outData_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_q + AW'(push);
            rdPtr_q <= rdPtr_q + AW'(pop);
            count_q <= count_d;
            room_q <= (count_d != (AW+1)'(DEPTH));
            if (pop) begin
                outData_q <= mem[rdPtr_q];
                outValid_q <= 1'b1;
            end else if (drain) begin
                outValid_q <= 1'b0;
            end
        end
    end

    assign inReady = room_q;
    assign outData = outData_q;
    assign outValid = outValid_q;

endmodule

`default_nettype wire

// ---- src/fao_output_port.sv ----
// digital output stage of an 8-bit flash converter
`timescale 1ns/1ps
`default_nettype none
`include "fao_cfg.svh"

module fao_output_port #(
    parameter int DATA_W = `FAO_DATA_W,
    parameter int FIFO_DEPTH = `FAO_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [DATA_W-1:0] sampleCode,
    input wire logic aboveRef,
    input wire logic output_enable_n,
    input wire logic output_enable_hi,
    output logic [DATA_W-1:0] sample_data_out,
    output logic sample_data_oe,
    output logic range_exceeded_out,
    output logic range_exceeded_oe,
    output logic [DATA_W:0] streamData,
    output logic streamValid,
    input wire logic streamReady,
    output logic convReady,
    output logic sampleLost
);

    // ------------------------------------------------------------
    // rate limits the clock source must respect
    // ------------------------------------------------------------
    // 25 MHz sits above the documented 20 MSPS ceiling; the pipeline
    // itself does not care, but analog accuracy falls off there
    // kept as a record for the clock source; no logic reads them
    localparam int CLK_KHZ = `FAO_CLK_KHZ;
    localparam int MAX_RATE_KSPS = `FAO_MAX_RATE_KSPS;
    localparam int MIN_RATE_KSPS = `FAO_MIN_RATE_KSPS;
    localparam int MIN_CLK_DIV = (CLK_KHZ + MAX_RATE_KSPS - 1) / MAX_RATE_KSPS;
    localparam int MAX_CLK_DIV = CLK_KHZ / MIN_RATE_KSPS;
    localparam int SYNC_N = `FAO_SYNC_STAGES;

    // ------------------------------------------------------------
    // enable pin synchronisers
    // ------------------------------------------------------------
    // the enables come straight from board pins, so each passes a
    // three-flop chain; the filtered level only moves once the last
    // two stages agree, which rejects a single-cycle glitch
    logic [1:0] enPin;
    logic [1:0] enSync1_q;
    logic [1:0] enSync2_q;
    logic [1:0] enSync3_q;
    logic [1:0] enLevel_q;

    assign enPin[`FAO_EN_N_IDX] = output_enable_n;
    assign enPin[`FAO_EN_HI_IDX] = output_enable_hi;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ensync
            // reset level: output_enable_n high keeps the data pins off and
            // output_enable_hi low floats both, so start from floating
            localparam logic RST_LVL = (gi == `FAO_EN_N_IDX);

            always_ff @(posedge clk) begin
                if (rst) begin
                    enSync1_q[gi] <= RST_LVL;
                    enSync2_q[gi] <= RST_LVL;
                    enSync3_q[gi] <= RST_LVL;
                    enLevel_q[gi] <= RST_LVL;
                end else begin
                    enSync1_q[gi] <= enPin[gi];
                    enSync2_q[gi] <= enSync1_q[gi];
                    enSync3_q[gi] <= enSync2_q[gi];
                    if (enSync2_q[gi] == enSync3_q[gi]) begin
                        enLevel_q[gi] <= enSync3_q[gi];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // drive mode decode
    // ------------------------------------------------------------
    // enable-high low wins over everything else
    wire enLowActive = !enLevel_q[`FAO_EN_N_IDX];
    wire enHighActive = enLevel_q[`FAO_EN_HI_IDX];
    wire fao_pkg::fao_drive_t driveMode =
        !enHighActive ? fao_pkg::FAO_DRIVE_NONE :
        enLowActive ? fao_pkg::FAO_DRIVE_ALL :
        fao_pkg::FAO_DRIVE_OVF;

    // per-pin enables for the chosen mode
    logic dataOe_d;
    logic ovfOe_d;
    always_comb begin
        case (driveMode)
            fao_pkg::FAO_DRIVE_ALL: begin
                dataOe_d = 1'b1;
                ovfOe_d = 1'b1;
            end
            fao_pkg::FAO_DRIVE_OVF: begin
                dataOe_d = 1'b0;
                ovfOe_d = 1'b1;
            end
            fao_pkg::FAO_DRIVE_NONE: begin
                dataOe_d = 1'b0;
                ovfOe_d = 1'b0;
            end
            // unused encoding: float both pins rather than guess
            default: begin
                dataOe_d = 1'b0;
                ovfOe_d = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // result encoding
    // ------------------------------------------------------------
    // above the top reference the code saturates so a cascaded upper
    // unit sees a clean all-ones word from the lower one
    wire [DATA_W-1:0] codeOnes = DATA_W'(`FAO_CODE_ALL_ONES);
    wire [DATA_W-1:0] result_d = aboveRef ? codeOnes : sampleCode;
    wire resultOvf_d = aboveRef;

    // ------------------------------------------------------------
    // output latches
    // ------------------------------------------------------------
    // loaded on every edge: the sample taken at edge n stands on the
    // pins from just after edge n until edge n+1, one clock of latency;
    // the falling edge load of the analog part maps onto the single
    // rising edge here, which trades half a cycle for one clock domain
    logic [DATA_W-1:0] result_q;
    logic resultOvf_q;
    logic resultValid_q;
    logic dataOe_q;
    logic ovfOe_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            result_q <= DATA_W'(`FAO_CODE_RESET);
            resultOvf_q <= `FAO_OVF_RESET;
            resultValid_q <= 1'b0;
        end else begin
            result_q <= result_d;
            resultOvf_q <= resultOvf_d;
            resultValid_q <= 1'b1;
        end
    end

    // enables registered so pins only switch on a clock edge
    always_ff @(posedge clk) begin
        if (rst) begin
            dataOe_q <= 1'b0;
            ovfOe_q <= 1'b0;
        end else begin
            dataOe_q <= dataOe_d;
            ovfOe_q <= ovfOe_d;
        end
    end

    // ------------------------------------------------------------
    // capture fifo
    // ------------------------------------------------------------
    // every latched word also goes to a 32-entry queue so slow capture
    // logic can take it at its own pace; the converter cannot pause,
    // so a full queue drops the word and flags it
    // the fifo's output register holds one word beyond the array, so a
    // stalled reader sees 33 words queued before the first drop
    wire [DATA_W:0] pushWord = {resultOvf_q, result_q};
    logic fifoRoom;

    fao_fifo #(
        .WIDTH(DATA_W + 1),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .inData(pushWord),
        .inValid(resultValid_q),
        .inReady(fifoRoom),
        .outData(streamData),
        .outValid(streamValid),
        .outReady(streamReady)
    );

    // sticky loss flag, cleared only by reset
    // no other clear exists, so a set can never race a clear
    wire lostNow = resultValid_q && !fifoRoom;
    logic sampleLost_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            sampleLost_q <= 1'b0;
        end else if (lostNow) begin
            sampleLost_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // pin outputs
    // ------------------------------------------------------------
    // every pin and status output is a bare flop, no logic after it
    assign sample_data_out = result_q;
    assign range_exceeded_out = resultOvf_q;
    assign sample_data_oe = dataOe_q;
    assign range_exceeded_oe = ovfOe_q;
    assign convReady = fifoRoom;
    assign sampleLost = sampleLost_q;

endmodule

`default_nettype wire

// ---- tb/fao_capture_model.sv ----
// capture logic model that drains the result stream
`timescale 1ns/1ps
`default_nettype none
module fao_capture_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [8:0] streamData,
    input wire logic streamValid,
    input wire logic stall,
    output logic streamReady,
    output logic [8:0] lastWord
);
    // ready only drops on command, so stalls are always deliberate
    assign streamReady = !stall;
    // keep the newest word taken
    always_ff @(posedge clk) begin
        if (rst) begin
            lastWord <= 9'h000;
        end else if (streamValid && streamReady) begin
            lastWord <= streamData;
        end
    end
endmodule
`default_nettype wire

// ---- tb/fao_output_port_properties.sv ----
// concurrent checks on the converter output port
`timescale 1ns/1ps
`default_nettype none
module fao_output_port_chk #(
    parameter int DATA_W = 8,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [DATA_W-1:0] sampleCode,
    input wire logic aboveRef,
    input wire logic output_enable_n,
    input wire logic output_enable_hi,
    input wire logic [DATA_W-1:0] sample_data_out,
    input wire logic sample_data_oe,
    input wire logic range_exceeded_out,
    input wire logic range_exceeded_oe,
    input wire logic [DATA_W:0] streamData,
    input wire logic streamValid,
    input wire logic streamReady,
    input wire logic convReady,
    input wire logic sampleLost
);
    // edges since reset; early edges still show reset values
    logic [3:0] upCnt_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            upCnt_q <= 4'h0;
        end else if (upCnt_q != 4'hf) begin
            upCnt_q <= upCnt_q + 4'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // enables held long enough to pass the filter
    sequence enAll;
        (!output_enable_n && output_enable_hi)[*6] ##0 upCnt_q > 4'h7;
    endsequence
    sequence enOvf;
        (output_enable_n && output_enable_hi)[*6] ##0 upCnt_q > 4'h7;
    endsequence
    sequence enNone;
        (!output_enable_hi)[*6] ##0 upCnt_q > 4'h7;
    endsequence
    chk_data_latency: assert property (upCnt_q != 4'h0 |->
        sample_data_out ==
            ($past(aboveRef) ? {DATA_W{1'b1}} : $past(sampleCode)))
        else $error("data word not last sample");
    chk_ovf_latency: assert property (upCnt_q != 4'h0 |->
        range_exceeded_out == $past(aboveRef))
        else $error("overflow lag wrong");
    chk_ovf_all_ones: assert property (range_exceeded_out |->
        sample_data_out == {DATA_W{1'b1}})
        else $error("overflow without ones");
    chk_drive_both: assert property (enAll |->
        sample_data_oe && range_exceeded_oe) else $error("outputs not driven");
    chk_drive_ovf: assert property (enOvf |->
        !sample_data_oe && range_exceeded_oe) else $error("wrong half drive");
    chk_float_all: assert property (enNone |->
        !sample_data_oe && !range_exceeded_oe)
        else $error("outputs not floated");
    chk_oe_pairing: assert property (
        sample_data_oe |-> range_exceeded_oe)
        else $error("data driven without overflow");
    chk_stream_hold: assert property (streamValid && !streamReady |=>
        streamValid && $stable(streamData)) else $error("head moved on stall");
    chk_loss_flag: assert property (!convReady || sampleLost |=>
        sampleLost) else $error("loss flag missing");
endmodule
bind fao_output_port fao_output_port_chk #(
    .DATA_W(DATA_W),
    .FIFO_DEPTH(FIFO_DEPTH)
) chk (
    .clk(clk),
    .rst(rst),
    .sampleCode(sampleCode),
    .aboveRef(aboveRef),
    .output_enable_n(output_enable_n),
    .output_enable_hi(output_enable_hi),
    .sample_data_out(sample_data_out),
    .sample_data_oe(sample_data_oe),
    .range_exceeded_out(range_exceeded_out),
    .range_exceeded_oe(range_exceeded_oe),
    .streamData(streamData),
    .streamValid(streamValid),
    .streamReady(streamReady),
    .convReady(convReady),
    .sampleLost(sampleLost)
);
`default_nettype wire

// ---- tb/fao_output_port_tb.sv ----
// self-checking bench for the converter output port
`timescale 1ns/1ps
`default_nettype none
module fao_output_port_tb;
    logic clk, rst, aboveRef, enableN, enableHi, stall, streamReady;
    logic streamValid, dataOe, ovfOe, ovf, convReady, sampleLost;
    logic [7:0] sampleCode, dataOut;
    logic [8:0] streamData, lastWord;
    int mismatches = 0;
    int comparisons = 0;
    fao_output_port dut (.clk(clk), .rst(rst), .sampleCode(sampleCode),
        .aboveRef(aboveRef), .output_enable_n(enableN),
        .output_enable_hi(enableHi), .sample_data_out(dataOut),
        .sample_data_oe(dataOe), .range_exceeded_out(ovf),
        .range_exceeded_oe(ovfOe), .streamData(streamData),
        .streamValid(streamValid), .streamReady(streamReady),
        .convReady(convReady), .sampleLost(sampleLost));
    fao_capture_model far (.clk(clk), .rst(rst), .streamData(streamData),
        .streamValid(streamValid), .stall(stall),
        .streamReady(streamReady), .lastWord(lastWord));
    // 40 ns clock: a touch above the 20 MSPS ceiling, logic is rate-blind
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic check(input string what, input logic [8:0] seen,
        input logic [8:0] want);
        comparisons++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic test_done;
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // back-to-back samples, overflow forcing all ones
    task automatic t_samples;
        logic [7:0] codes [8] = '{8'h00, 8'h01, 8'h80, 8'h7f, 8'hfe,
            8'hff, 8'h5a, 8'h00};
        logic [8:0] want;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            sampleCode <= codes[i];
            aboveRef <= (i == 3 || i == 6);
            #1;
            if (i > 0) begin
                want = (i == 4 || i == 7) ? 9'h1ff : {1'b0, codes[i-1]};
                check("pins", {ovf, dataOut}, want);
            end
        end
    endtask
    // every enable mode, then a one-cycle pulse that must be ignored
    task automatic t_enables;
        logic [1:0] modes [5] = '{2'b01, 2'b11, 2'b00, 2'b10, 2'b11};
        logic [1:0] oes [5] = '{2'b11, 2'b01, 2'b00, 2'b00, 2'b01};
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            {enableN, enableHi} <= modes[i];
            repeat (6) @(posedge clk);
            #1;
            check("oe", {7'h00, dataOe, ovfOe}, 9'(oes[i]));
        end
        @(posedge clk);
        enableN <= 1'b0;
        @(posedge clk);
        enableN <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        check("oe pulse", {7'h00, dataOe, ovfOe}, 9'h001);
    endtask
    // stream pairing, then stall until the fifo refuses, then drain
    task automatic t_stream;
        @(posedge clk);
        sampleCode <= 8'h5a;
        aboveRef <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check("word", lastWord, 9'h05a);
        @(posedge clk);
        aboveRef <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        check("word ovf", lastWord, 9'h1ff);
        @(posedge clk);
        stall <= 1'b1;
        repeat (40) @(posedge clk);
        #1;
        check("full", {7'h00, convReady, sampleLost}, 9'h001);
        @(posedge clk);
        stall <= 1'b0;
        repeat (40) @(posedge clk);
        #1;
        check("drained", {7'h00, convReady, sampleLost}, 9'h003);
    endtask
    initial begin
        rst = 1'b1;
        sampleCode = 8'h00;
        aboveRef = 1'b0;
        enableN = 1'b1;
        enableHi = 1'b0;
        stall = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        check("reset", {dataOe, ovfOe, ovf, convReady, streamValid,
            sampleLost, dataOut[2:0]}, 9'h020);
        t_samples();
        t_enables();
        t_stream();
        test_done();
    end
    // run needs about 150 cycles; cut a hang well past that
    initial begin
        #100000;
        mismatches++;
        test_done();
    end
endmodule
`default_nettype wire
